// ==== dv/rag_top_sva.sv ====
/*
 * Checker for the right-channel AGC configuration block: APB answer timing,
 * gain capping, timer spacing and noise gate behaviour.
 * Assumes it is bound to rag_top and sees only that module's ports.
 */
`timescale 1ns/10ps
module rag_chk (
    // Clock and reset
    input wire        CLOCK,
    input wire        RESET_N,
    // APB
    input wire        PSEL,
    input wire        PENABLE,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    // AGC side
    input wire        WORD_CLK,
    input wire [6:0]  GAIN_REQ,
    input wire        NOISE_LOW,
    input wire [6:0]  GAIN_OUT,
    input wire [6:0]  GAIN_CEIL,
    input wire        ATTACK_TICK,
    input wire        DECAY_TICK,
    input wire        NOISE_GATE
);
    // ---------------------------------------------------------------
    // Word clock edges since last tick
    // ---------------------------------------------------------------
    reg        wp;
    reg [19:0] ac;
    reg [19:0] dc;
    wire       rise = WORD_CLK & ~wp;
    always @(posedge CLOCK) begin
        wp <= WORD_CLK;
        if (!RESET_N) begin
            ac <= 20'h00000;
            dc <= 20'h00000;
        end else begin
            ac <= ATTACK_TICK ? {19'h00000, rise} : ac + {19'h00000, rise};
            dc <= DECAY_TICK ? {19'h00000, rise} : dc + {19'h00000, rise};
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    property p_ceil_cap; GAIN_CEIL <= 7'h74; endproperty
    a_ceil_cap: assert property (p_ceil_cap) else $error("ceiling above top code");
    property p_gain_cap; GAIN_OUT <= GAIN_CEIL; endproperty
    a_gain_cap: assert property (p_gain_cap) else $error("gain above ceiling");
    property p_gain_min;
        ($stable(GAIN_CEIL) && GAIN_CEIL != 7'h00) |->
            GAIN_OUT == (($past(GAIN_REQ) < GAIN_CEIL) ? $past(GAIN_REQ) : GAIN_CEIL);
    endproperty
    a_gain_min: assert property (p_gain_min) else $error("gain not min of request");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held over");
    property p_ready_time; (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY; endproperty
    a_ready_time: assert property (p_ready_time) else $error("ready late");
    property p_err_data; PSLVERR |-> PREADY && PRDATA == 32'h00000000; endproperty
    a_err_data: assert property (p_err_data) else $error("bad error answer");
    property p_atk_min; ATTACK_TICK |-> ac >= 20'h00020 ##1 !ATTACK_TICK; endproperty
    a_atk_min: assert property (p_atk_min) else $error("attack too soon");
    property p_dcy_min; DECAY_TICK |-> dc >= 20'h00200 ##1 !DECAY_TICK; endproperty
    a_dcy_min: assert property (p_dcy_min) else $error("decay too soon");
    property p_gate_drop; !NOISE_LOW [*2] |=> !NOISE_GATE; endproperty
    a_gate_drop: assert property (p_gate_drop) else $error("gate held");
    property p_gate_cause; NOISE_GATE |-> $past(NOISE_LOW); endproperty
    a_gate_cause: assert property (p_gate_cause) else $error("gate without noise");
    c_atk: cover property (ATTACK_TICK);
    c_dcy: cover property (DECAY_TICK);
    c_gate: cover property ($rose(NOISE_GATE));
    c_err: cover property (PSLVERR);
endmodule // rag_chk
bind rag_top rag_chk rag_chk_i (.CLOCK, .RESET_N, .PSEL, .PENABLE, .PRDATA, .PREADY, .PSLVERR,
    .WORD_CLK, .GAIN_REQ, .NOISE_LOW, .GAIN_OUT, .GAIN_CEIL, .ATTACK_TICK, .DECAY_TICK,
    .NOISE_GATE);

// ==== dv/rag_top_tb.sv ====
/*
 * Self-checking bench for the right-channel AGC configuration block.
 * Assumes rag_top with its APB slave and the block's defines header.
 */
`timescale 1ns/10ps
`include "rag_defs.vh"
module rag_top_tb;
    reg CLOCK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, WORD_CLK = 0, NOISE_LOW = 0;
    reg [11:0] PADDR = 12'h000;
    reg [31:0] PWDATA = 32'h00000000;
    reg [6:0]  GAIN_REQ = 7'h00;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, ATTACK_TICK, DECAY_TICK, NOISE_GATE;
    wire [6:0] GAIN_OUT, GAIN_CEIL;
    reg [1:0] wdiv = 2'h0;
    reg wq = 0;
    int wcnt = 0, miscompares = 0, check_count = 0, a, b, i;
    reg [31:0] q;
    reg e;
    rag_top rag_top_i (.CLOCK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .WORD_CLK, .GAIN_REQ, .NOISE_LOW, .GAIN_OUT, .GAIN_CEIL,
        .ATTACK_TICK, .DECAY_TICK, .NOISE_GATE);
    initial begin
        forever #20 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        wdiv <= wdiv + 2'h1;
        WORD_CLK <= wdiv[0];
        wq <= WORD_CLK;
        if (WORD_CLK && !wq) wcnt <= wcnt + 1;
    end
    // ---------------------------------------------------------------
    // Access and check tasks
    // ---------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task chkn(input int got, input int lo, input int hi);
        chk({31'h0, got >= lo && got <= hi}, 32'h00000001);
    endtask
    task apb(input bit wr, input [11:0] ad, input [31:0] d);
        @(posedge CLOCK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, wr, ad, d};
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1) @(posedge CLOCK);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task wr(input [11:0] ad, input [31:0] d);
        apb(1, ad, d);
        chk({31'h0, e}, 32'h00000000);
    endtask
    task rd(input [11:0] ad, input [31:0] exp);
        apb(0, ad, 0);
        chk(q, exp);
    endtask
    function automatic logic ev(int s);
        ev = (s == 0) ? ATTACK_TICK : (s == 1) ? DECAY_TICK : NOISE_GATE;
    endfunction
    task wait_ev(input int s, output int w);
        for (i = 0; i < 200000 && ev(s) !== 1'b1; i++) @(negedge CLOCK);
        w = wcnt;
        @(negedge CLOCK);
    endtask
    task period(input int s, input [11:0] ad, input [31:0] code, input int len);
        wr(ad, code);
        wait_ev(s, a);
        wait_ev(s, a);
        wait_ev(s, b);
        chkn(b - a, len, len);
    endtask
    task debounce(input [31:0] code, input int len);
        wr(`RAG_ADDR_DEBOUNCE, code);
        @(posedge CLOCK);
        NOISE_LOW <= 1'b1;
        a = wcnt;
        wait_ev(2, b);
        chkn(b - a, len - 1, len + 1);
        NOISE_LOW <= 1'b0;
        repeat (4) @(posedge CLOCK);
    endtask
    task ceil_case(input [6:0] code, input [6:0] eff);
        wr(`RAG_ADDR_CEIL, {25'h0000000, code});
        repeat (4) @(posedge CLOCK);
        chk(GAIN_CEIL, eff);
        chk(GAIN_OUT, (eff < 7'h20) ? eff : 7'h20);
    endtask
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge CLOCK);
        miscompares++;
        give_verdict;
    end
    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge CLOCK);
        RESET_N <= 1'b1;
        rd(`RAG_ADDR_CEIL, 32'h0000007F);
        rd(`RAG_ADDR_ATTACK, 32'h00000000);
        rd(`RAG_ADDR_DECAY, 32'h00000000);
        rd(`RAG_ADDR_DEBOUNCE, 32'h00000000);
        wr(`RAG_ADDR_DEBOUNCE, 32'h0000001F);
        rd(`RAG_ADDR_DEBOUNCE, 32'h0000001F);
        wr(`RAG_ADDR_ATTACK, 32'h000000A5);
        rd(`RAG_ADDR_ATTACK, 32'h000000A5);
        apb(0, 12'h1FC, 0);
        chk({q[30:0], e}, 32'h00000001);
        GAIN_REQ <= 7'h20;
        repeat (4) @(posedge CLOCK);
        chk(GAIN_OUT, 32'h00000000);
        wr(`RAG_ADDR_CTRL, 32'h00000080);
        rd(`RAG_ADDR_CTRL, 32'h00000080);
        ceil_case(7'h00, 7'h00);
        ceil_case(7'h10, 7'h10);
        ceil_case(7'h74, 7'h74);
        ceil_case(7'h75, 7'h74);
        ceil_case(7'h7F, 7'h74);
        rd(`RAG_ADDR_STATUS, 32'h00742000);
        rd(`RAG_ADDR_CEIL, 32'h0000007F);
        period(0, `RAG_ADDR_ATTACK, 32'h00000000, 32);
        period(0, `RAG_ADDR_ATTACK, 32'h00000009, 192);
        period(0, `RAG_ADDR_ATTACK, 32'h00000002, 128);
        period(1, `RAG_ADDR_DECAY, 32'h00000000, 512);
        period(1, `RAG_ADDR_DECAY, 32'h00000009, 3072);
        debounce(32'h00000000, 0);
        debounce(32'h00000001, 0);
        debounce(32'h00000002, 4);
        debounce(32'h00000003, 8);
        debounce(32'h00000005, 32);
        debounce(32'h0000000A, 2048);
        debounce(32'h0000000B, 4096);
        debounce(32'h0000000C, 8192);
        wr(`RAG_ADDR_CTRL, 32'h00000000);
        repeat (4) @(posedge CLOCK);
        chk({GAIN_OUT, GAIN_CEIL}, 32'h00000000);
        give_verdict;
    end
endmodule // rag_top_tb

// ==== rtl/rag_defs.vh ====
/*
 * Constants for the right-channel AGC timing and gain configuration block.
 * Assumes inclusion by the block's design file and its bench.
 */
`ifndef RAG_DEFS_VH
`define RAG_DEFS_VH

// ---------------------------------------------------------------
// Register indices and byte addresses
// ---------------------------------------------------------------
`define RAG_IDX_CEIL        8'h60
`define RAG_IDX_ATTACK      8'h61
`define RAG_IDX_DECAY       8'h62
`define RAG_IDX_DEBOUNCE    8'h63
`define RAG_IDX_CTRL        8'h5E
`define RAG_IDX_STATUS      8'h70
`define RAG_ADDR_W          12
`define RAG_ADDR_CEIL       12'h180
`define RAG_ADDR_ATTACK     12'h184
`define RAG_ADDR_DECAY      12'h188
`define RAG_ADDR_DEBOUNCE   12'h18C
`define RAG_ADDR_CTRL       12'h178
`define RAG_ADDR_STATUS     12'h1C0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RAG_RST_CEIL        7'h7F
`define RAG_RST_TIMING      8'h00
`define RAG_RST_DEBOUNCE    5'h00
`define RAG_RST_CTRL        1'h0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RAG_CTRL_EN_BIT     7
`define RAG_ST_GATE_BIT     0
`define RAG_ST_GAIN_LSB     8
`define RAG_ST_CEIL_LSB     16

// ---------------------------------------------------------------
// Gain ceiling limits, 0.5 dB per code
// ---------------------------------------------------------------
`define RAG_CEIL_MAX        7'h74

// ---------------------------------------------------------------
// Timing bases as shifts in word clocks
// ---------------------------------------------------------------
`define RAG_ATK_BASE_SH     5
`define RAG_DCY_BASE_SH     9
`define RAG_TIME_W          22
`define RAG_DEB_W           17
`define RAG_DEB_STEP        17'h01000
`define RAG_DEB_LIN_OFS     5'h0A
`define RAG_DEB_LIN_MAX     5'h1D
`define RAG_DEB_TOP         17'h14000
`define RAG_DEB_C10         17'h00800
`define RAG_DEB_C11         17'h01000
`define RAG_DEB_C11_CODE_GUARD 5'h0B

`endif

// ==== rtl/rag_top.v ====
/*
 * Right-channel AGC timing and gain configuration block with APB slave.
 * Assumes a 25 MHz CLOCK, an ADC word clock arriving on a pin, and AGC
 * arithmetic on CLOCK that supplies a raw gain request and noise level.
 */
// Functional notes
// - Ceiling code linear, 0.5 dB steps, gain capped
// - Codes above 58.0 dB act as 58.0
// - Attack time (2N+1) times 32 word clocks
// - Attack time scaled by two to K
// - Decay time (2N+1) times 512 word clocks
// - Decay time scaled by own two to K
// - Debounce codes two to nine doubling, ten and eleven 2048 and 4096
// - Debounce codes twelve to thirty linear 4096 steps, 31 as 30
// - Limits and timers act only when enabled
`timescale 1ns/10ps
`include "rag_defs.vh"

module rag_top (
    // Clock and reset
    input  wire        CLOCK,
    input  wire        RESET_N,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // ADC word clock pin
    input  wire        WORD_CLK,
    // AGC arithmetic side
    input  wire [6:0]  GAIN_REQ,
    input  wire        NOISE_LOW,
    output reg  [6:0]  GAIN_OUT,
    output reg  [6:0]  GAIN_CEIL,
    output reg         ATTACK_TICK,
    output reg         DECAY_TICK,
    output reg         NOISE_GATE
);

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
reg [6:0]  ceil_code;
reg [7:0]  attack_cfg;
reg [7:0]  decay_cfg;
reg [4:0]  deb_code;
reg        agc_en;

// ---------------------------------------------------------------
// Word clock synchroniser and edge
// ---------------------------------------------------------------
reg        wclk_s1;
reg        wclk_s2;
reg        wclk_s3;
wire       word_tick;

always @(posedge CLOCK) begin
    if (!RESET_N) begin
        wclk_s1 <= 1'b0;
        wclk_s2 <= 1'b0;
        wclk_s3 <= 1'b0;
    end else begin
        wclk_s1 <= WORD_CLK;
        wclk_s2 <= wclk_s1;
        wclk_s3 <= wclk_s2;
    end
end

// ---------------------------------------------------------------
// Word tick
// ---------------------------------------------------------------

assign word_tick = wclk_s2 & ~wclk_s3;

// ---------------------------------------------------------------
// Decoded settings
// ---------------------------------------------------------------
wire [6:0]                 ceil_eff;
wire [`RAG_TIME_W-1:0]     attack_len;
wire [`RAG_TIME_W-1:0]     decay_len;
wire [`RAG_TIME_W-1:0]     attack_odd;
wire [`RAG_TIME_W-1:0]     decay_odd;
reg  [`RAG_DEB_W-1:0]      deb_len;
reg  [`RAG_DEB_W-1:0]      deb_mul;

assign ceil_eff = (ceil_code > `RAG_CEIL_MAX) ? `RAG_CEIL_MAX : ceil_code;

// ---------------------------------------------------------------
// Attack and decay lengths
// ---------------------------------------------------------------

assign attack_odd = {{(`RAG_TIME_W-6){1'b0}}, attack_cfg[7:3], 1'b1};
assign decay_odd  = {{(`RAG_TIME_W-6){1'b0}}, decay_cfg[7:3], 1'b1};

assign attack_len = attack_odd << (attack_cfg[2:0] + `RAG_ATK_BASE_SH);
assign decay_len  = decay_odd << (decay_cfg[2:0] + `RAG_DCY_BASE_SH);

// ---------------------------------------------------------------
// Debounce length decode
// ---------------------------------------------------------------

always @* begin
    deb_mul = {{(`RAG_DEB_W-5){1'b0}}, deb_code - `RAG_DEB_LIN_OFS};
    case (deb_code)
        5'h00,
        5'h01: begin
            deb_len = {`RAG_DEB_W{1'b0}};
        end
        5'h0A: begin
            deb_len = `RAG_DEB_C10;
        end
        5'h0B: begin
            deb_len = `RAG_DEB_C11;
        end
        5'h1E,
        5'h1F: begin
            deb_len = `RAG_DEB_TOP;
        end
        default: begin
            if (deb_code > `RAG_DEB_C11_CODE_GUARD)
                deb_len = deb_mul * `RAG_DEB_STEP;
            else
                deb_len = {{(`RAG_DEB_W-1){1'b0}}, 1'b1} << deb_code;
        end
    endcase
end

// ---------------------------------------------------------------
// Attack and decay timers
// ---------------------------------------------------------------
reg [`RAG_TIME_W-1:0] attack_cnt;
reg [`RAG_TIME_W-1:0] decay_cnt;
wire                  attack_wrap;
wire                  decay_wrap;

assign attack_wrap = (attack_cnt >= attack_len - 1'b1);
assign decay_wrap  = (decay_cnt >= decay_len - 1'b1);

always @(posedge CLOCK) begin
    if (!RESET_N) begin
        attack_cnt  <= {`RAG_TIME_W{1'b0}};
        decay_cnt   <= {`RAG_TIME_W{1'b0}};
        ATTACK_TICK <= 1'b0;
        DECAY_TICK  <= 1'b0;
    end else if (!agc_en) begin
        attack_cnt  <= {`RAG_TIME_W{1'b0}};
        decay_cnt   <= {`RAG_TIME_W{1'b0}};
        ATTACK_TICK <= 1'b0;
        DECAY_TICK  <= 1'b0;
    end else begin
        ATTACK_TICK <= word_tick & attack_wrap;
        DECAY_TICK  <= word_tick & decay_wrap;
        if (word_tick) begin
            if (attack_wrap)
                attack_cnt <= {`RAG_TIME_W{1'b0}};
            else
                attack_cnt <= attack_cnt + 1'b1;
            if (decay_wrap)
                decay_cnt <= {`RAG_TIME_W{1'b0}};
            else
                decay_cnt <= decay_cnt + 1'b1;
        end
    end
end

// ---------------------------------------------------------------
// Noise debounce
// ---------------------------------------------------------------
reg [`RAG_DEB_W-1:0] deb_cnt;

always @(posedge CLOCK) begin
    if (!RESET_N) begin
        deb_cnt    <= {`RAG_DEB_W{1'b0}};
        NOISE_GATE <= 1'b0;
    end else if (!agc_en || !NOISE_LOW) begin
        deb_cnt    <= {`RAG_DEB_W{1'b0}};
        NOISE_GATE <= 1'b0;
    end else if (deb_cnt >= deb_len) begin
        NOISE_GATE <= 1'b1;
    end else if (word_tick) begin
        deb_cnt <= deb_cnt + 1'b1;
    end
end

// ---------------------------------------------------------------
// Gain limiting
// ---------------------------------------------------------------
always @(posedge CLOCK) begin
    if (!RESET_N) begin
        GAIN_OUT  <= 7'h00;
        GAIN_CEIL <= 7'h00;
    end else if (!agc_en) begin
        GAIN_OUT  <= 7'h00;
        GAIN_CEIL <= 7'h00;
    end else begin
        GAIN_CEIL <= ceil_eff;
        GAIN_OUT  <= (GAIN_REQ > ceil_eff) ? ceil_eff : GAIN_REQ;
    end
end

// ---------------------------------------------------------------
// APB slave
// ---------------------------------------------------------------
wire        apb_access;
wire        apb_wr;
reg         addr_hit;
reg  [31:0] rd_mux;

assign apb_access = PSEL & PENABLE;
assign apb_wr     = apb_access & PREADY & PWRITE & addr_hit;

// ---------------------------------------------------------------
// Read multiplexer
// ---------------------------------------------------------------

always @* begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (PADDR)
        `RAG_ADDR_CEIL: begin
            rd_mux[6:0] = ceil_code;
        end
        `RAG_ADDR_ATTACK: begin
            rd_mux[7:0] = attack_cfg;
        end
        `RAG_ADDR_DECAY: begin
            rd_mux[7:0] = decay_cfg;
        end
        `RAG_ADDR_DEBOUNCE: begin
            rd_mux[4:0] = deb_code;
        end
        `RAG_ADDR_CTRL: begin
            rd_mux[`RAG_CTRL_EN_BIT] = agc_en;
        end
        `RAG_ADDR_STATUS: begin
            rd_mux[`RAG_ST_GATE_BIT]              = NOISE_GATE;
            rd_mux[`RAG_ST_GAIN_LSB+6:`RAG_ST_GAIN_LSB] = GAIN_OUT;
            rd_mux[`RAG_ST_CEIL_LSB+6:`RAG_ST_CEIL_LSB] = GAIN_CEIL;
        end
        default: begin
            addr_hit = 1'b0;
        end
    endcase
end

// ---------------------------------------------------------------
// APB answer, one cycle into the access phase
// ---------------------------------------------------------------
always @(posedge CLOCK) begin
    if (!RESET_N) begin
        PREADY  <= 1'b0;
        PRDATA  <= 32'h0000_0000;
        PSLVERR <= 1'b0;
    end else if (apb_access && !PREADY) begin
        PREADY  <= 1'b1;
        PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
        PSLVERR <= ~addr_hit;
    end else begin
        PREADY  <= 1'b0;
        PRDATA  <= 32'h0000_0000;
        PSLVERR <= 1'b0;
    end
end

// ---------------------------------------------------------------
// Register writes; reserved bits are not stored
// ---------------------------------------------------------------
always @(posedge CLOCK) begin
    if (!RESET_N) begin
        ceil_code  <= `RAG_RST_CEIL;
        attack_cfg <= `RAG_RST_TIMING;
        decay_cfg  <= `RAG_RST_TIMING;
        deb_code   <= `RAG_RST_DEBOUNCE;
        agc_en     <= `RAG_RST_CTRL;
    end else if (apb_wr) begin
        case (PADDR)
            `RAG_ADDR_CEIL: begin
                ceil_code <= PWDATA[6:0];
            end
            `RAG_ADDR_ATTACK: begin
                attack_cfg <= PWDATA[7:0];
            end
            `RAG_ADDR_DECAY: begin
                decay_cfg <= PWDATA[7:0];
            end
            `RAG_ADDR_DEBOUNCE: begin
                deb_code <= PWDATA[4:0];
            end
            `RAG_ADDR_CTRL: begin
                agc_en <= PWDATA[`RAG_CTRL_EN_BIT];
            end
            default: begin
                agc_en <= agc_en;
            end
        endcase
    end
end

endmodule // rag_top
